/* File: inc/cts_pkg.sv */
/*
 * Constants of the control table sequencer: register map, field
 * positions, table bit columns, counter widths and fixed values.
 * Assumes a 32-bit APB slave with byte addresses.
 */
package cts_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_TADDR = 8'h04;
	localparam logic [7:0] OFS_VWR   = 8'h08;
	localparam logic [7:0] OFS_HWR   = 8'h0C;
	localparam logic [7:0] OFS_VPOS  = 8'h10;
	localparam logic [7:0] OFS_HPOS  = 8'h14;
	localparam logic [7:0] OFS_TOUT  = 8'h18;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int C_RUN   = 0;
	localparam int C_FEDGE = 1;
	localparam int C_LEDGE = 2;
	localparam int C_FZERO = 3;
	localparam int C_FCLR  = 4;
	localparam int C_FSTK  = 6;
	localparam int C_LZERO = 7;
	localparam int C_LSTK  = 8;
	localparam int C_VWTAB = 9;
	localparam int CTRL_W  = 10;
	localparam logic [9:0] CTRL_RST = 10'h006;

	localparam logic [1:0] FCLR_TABLE = 2'h0;
	localparam logic [1:0] FCLR_TRIG  = 2'h1;
	localparam logic [1:0] FCLR_BOTH  = 2'h2;
	localparam logic [1:0] FCLR_NONE  = 2'h3;

	// ------------------------------------------------------------
	// Table columns
	// ------------------------------------------------------------
	localparam int TB_BEGIN = 0;
	localparam int TB_CLEAR = 1;
	localparam int TB_LMASK = 2;
	localparam int TB_IRQ   = 3;
	localparam int TB_GP    = 4;

	// ------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------
	localparam int V_W = 17;
	localparam int H_W = 15;
	localparam int V_DEPTH = 32'h0002_0000;
	localparam int H_DEPTH = 32'h0000_8000;
	localparam logic [16:0] V_LOAD  = 17'h0_8000;
	localparam logic [16:0] V_STICK = 17'h0_7FF0;
	localparam logic [16:0] V_ONE   = 17'h0_0001;
	localparam logic [14:0] H_LOAD  = 15'h2000;
	localparam logic [14:0] H_STICK = 15'h1FF0;
	localparam logic [14:0] H_ONE   = 15'h0001;
	localparam logic [2:0]  PDIV_LAST = 3'h7;

endpackage

/* File: rtl/cts_sequencer.sv */
/*
 * Vertical and horizontal control table sequencer with APB access.
 * Camera pixel clock, frame/line valid, trigger and encoder arrive
 * as pins asynchronous to clk_sys and are synchronised here.
 * The pixel clock must stay below a quarter of clk_sys.
 */
//
// Contract
// - Frame position counter is 17 bits, addresses vertical table; inc, load, reset.
// - Vertical load sets frame position counter to 8000h on count clock.
// - Vertical reset clears counter; reset beats load.
// - Table vertical clear bit with frame-valid load: the load wins.
// - Vertical entry bits: begin, clear, load mask, interrupt, four functions.
// - Free-running frame counter scans upward and wraps over all entries.
// - Inhibited increment holds counter; load and reset still act.
// - Frame counter counts once per line, at horizontal clear.
// - At zero, selectable: keep counting or wait for trigger.
// - Stick option stops frame counter at 7FF0h until frame-valid loads.
// - Frame-valid selected edge loads 8000h only when entry mask set.
// - Vertical clear source taken from clear source select field.
// - Entry interrupt bit raises host interrupt.
// - Table-sourced vertical window begins at entry with begin bit.
// - Vertical table holds 20000h entries.
// - Line position counter is 15 bits, clocked at pixel clock over eight.
// - Horizontal table is 8 bits wide, addressed by line counter.
// - Horizontal functions span up to 256K pixel clocks, 8-clock steps.
// - Horizontal load sets line counter to 2000h.
// - Horizontal reset clears line counter; reset beats load.
// - Free-running line counter scans upward and wraps.
// - Inhibited line increment holds; load and reset still act.
// - Horizontal bits: begin, clear and frame clock, mask, reserved, functions.
// - Line counter sticks at 1FF0h until line-valid loads 2000h.
// - Line-valid selected edge loads 2000h only when entry mask set.
// - Four combined outputs are vertical AND horizontal function bits.
`timescale 1ns/1ps
module cts_sequencer (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pixel_clock_in,
	input  wire logic        frame_valid_input,
	input  wire logic        line_valid_input,
	input  wire logic        trigger_in,
	input  wire logic        encoder_in,
	output logic             vertical_window_begin,
	output logic             horizontal_window_begin,
	output logic             table_interrupt,
	output logic [3:0]       general_vertical_function,
	output logic [3:0]       general_horizontal_function,
	output logic [3:0]       combined_waveform
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  pclk_s;
		logic [2:0]  fv_s;
		logic [2:0]  lv_s;
		logic [2:0]  trg_s;
		logic [2:0]  enc_s;
		logic [2:0]  div;
		logic        htick;
		logic [16:0] vpos;
		logic [14:0] hpos;
		logic        fpend;
		logic        lpend;
		logic        tpend;
		logic        epend;
		logic [1:0]  vn;
		logic [1:0]  hn;
		logic [9:0]  ctrl;
		logic [16:0] taddr;
		logic [31:0] prdata;
		logic        vbeg;
		logic        hbeg;
		logic        irq;
		logic [3:0]  cw;
	} cts_st_s;

	cts_st_s     q;
	cts_st_s     d;
	logic [7:0]  vtab [cts_pkg::V_DEPTH];
	logic [7:0]  htab [cts_pkg::H_DEPTH];
	logic [7:0]  vdat;
	logic [7:0]  hdat;

	logic        wr_en;
	logic        rd_setup;
	logic        pclk_rise;
	logic        frame_edge;
	logic        line_edge;
	logic        trg_rise;
	logic        enc_rise;
	logic        vtick;
	logic        fload;
	logic        vclr;
	logic        vzhold;
	logic        vstick;
	logic        vinc;
	logic        hload;
	logic        hclr;
	logic        hzhold;
	logic        hstick;
	logic        hinc;
	logic [1:0]  fclr_sel;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == cts_pkg::OFS_CTRL) || (a == cts_pkg::OFS_TADDR) ||
			(a == cts_pkg::OFS_VWR) || (a == cts_pkg::OFS_HWR) ||
			(a == cts_pkg::OFS_VPOS) || (a == cts_pkg::OFS_HPOS) ||
			(a == cts_pkg::OFS_TOUT);
	endfunction

	function automatic logic pick_edge(input logic rise_sel, input logic [2:0] s);
		pick_edge = rise_sel ? (s[1] & ~s[2]) : (~s[1] & s[2]);
	endfunction

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// Zero wait states; unmapped addresses answer with an error
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~mapped(paddr);
	assign prdata   = q.prdata;
	assign wr_en    = psel & penable & pwrite & mapped(paddr);
	assign rd_setup = psel & ~penable & ~pwrite;

	// ------------------------------------------------------------
	// Table memories
	// ------------------------------------------------------------
	// Tables have no reset; software fills them before setting run
	always_ff @(posedge clk_sys) begin
		if (wr_en && paddr == cts_pkg::OFS_VWR) begin
			vtab[q.taddr] <= pwdata[7:0];
		end
		if (wr_en && paddr == cts_pkg::OFS_HWR) begin
			htab[q.taddr[14:0]] <= pwdata[7:0];
		end
		vdat <= vtab[q.vpos];
		hdat <= htab[q.hpos];
	end

	// ------------------------------------------------------------
	// Event decode
	// ------------------------------------------------------------
	assign pclk_rise  = q.pclk_s[1] & ~q.pclk_s[2];
	assign frame_edge = pick_edge(q.ctrl[cts_pkg::C_FEDGE], q.fv_s);
	assign line_edge  = pick_edge(q.ctrl[cts_pkg::C_LEDGE], q.lv_s);
	assign trg_rise   = q.trg_s[1] & ~q.trg_s[2];
	assign enc_rise   = q.enc_s[1] & ~q.enc_s[2];
	assign fclr_sel   = q.ctrl[cts_pkg::C_FCLR +: 2];

	// Frame counter is clocked by the line's horizontal clear
	assign vtick = q.htick & hdat[cts_pkg::TB_CLEAR];

	// ------------------------------------------------------------
	// Vertical controls
	// ------------------------------------------------------------
	assign fload = q.fpend & vdat[cts_pkg::TB_LMASK];

	always_comb begin
		unique case (fclr_sel)
			cts_pkg::FCLR_TABLE: vclr = vdat[cts_pkg::TB_CLEAR] & ~fload;
			cts_pkg::FCLR_TRIG:  vclr = q.tpend;
			cts_pkg::FCLR_BOTH:  vclr = q.tpend | (vdat[cts_pkg::TB_CLEAR] & ~fload);
			cts_pkg::FCLR_NONE:  vclr = 1'b0;
		endcase
	end

	assign vzhold = q.ctrl[cts_pkg::C_FZERO] & (q.vpos == '0) & ~q.tpend;
	assign vstick = q.ctrl[cts_pkg::C_FSTK] & (q.vpos == cts_pkg::V_STICK);
	assign vinc   = q.ctrl[cts_pkg::C_RUN] & ~vzhold & ~vstick;

	// ------------------------------------------------------------
	// Horizontal controls
	// ------------------------------------------------------------
	assign hload  = q.lpend & hdat[cts_pkg::TB_LMASK];
	assign hclr   = hdat[cts_pkg::TB_CLEAR];
	assign hzhold = q.ctrl[cts_pkg::C_LZERO] & (q.hpos == '0) & ~q.epend;
	assign hstick = q.ctrl[cts_pkg::C_LSTK] & (q.hpos == cts_pkg::H_STICK);
	assign hinc   = q.ctrl[cts_pkg::C_RUN] & ~hzhold & ~hstick;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.pclk_s = {q.pclk_s[1:0], pixel_clock_in};
		d.fv_s   = {q.fv_s[1:0], frame_valid_input};
		d.lv_s   = {q.lv_s[1:0], line_valid_input};
		d.trg_s  = {q.trg_s[1:0], trigger_in};
		d.enc_s  = {q.enc_s[1:0], encoder_in};

		// Pixel clock over eight: one tick per eight rising edges
		d.htick = 1'b0;
		if (pclk_rise) begin
			d.div = q.div + 3'h1;
			d.htick = (q.div == cts_pkg::PDIV_LAST);
		end

		// Events are held until the count clock consumes them
		d.fpend = frame_edge | (q.fpend & ~vtick);
		d.lpend = line_edge | (q.lpend & ~q.htick);
		d.tpend = trg_rise | (q.tpend & ~(vtick & (vclr | (q.vpos == '0))));
		d.epend = enc_rise | (q.epend & ~(q.htick & (q.hpos == '0)));

		// Frame position counter
		if (vtick) begin
			if (vclr) begin
				d.vpos = '0;
			end else if (fload) begin
				d.vpos = cts_pkg::V_LOAD;
			end else if (vinc) begin
				d.vpos = q.vpos + cts_pkg::V_ONE;
			end
		end

		// Line position counter
		if (q.htick) begin
			if (hclr) begin
				d.hpos = '0;
			end else if (hload) begin
				d.hpos = cts_pkg::H_LOAD;
			end else if (hinc) begin
				d.hpos = q.hpos + cts_pkg::H_ONE;
			end
		end

		// New entry valid two cycles after the count clock
		d.vn = {q.vn[0], vtick};
		d.hn = {q.hn[0], q.htick};

		if (q.ctrl[cts_pkg::C_VWTAB]) begin
			d.vbeg = q.vn[1] & vdat[cts_pkg::TB_BEGIN];
		end else begin
			d.vbeg = frame_edge;
		end
		d.hbeg = q.hn[1] & hdat[cts_pkg::TB_BEGIN];
		d.irq  = q.vn[1] & vdat[cts_pkg::TB_IRQ];
		d.cw   = vdat[cts_pkg::TB_GP +: 4] & hdat[cts_pkg::TB_GP +: 4];

		// Register writes
		if (wr_en && paddr == cts_pkg::OFS_CTRL) begin
			d.ctrl = pwdata[cts_pkg::CTRL_W-1:0];
		end
		if (wr_en && paddr == cts_pkg::OFS_TADDR) begin
			d.taddr = pwdata[16:0];
		end

		// Read data captured in setup, stable through access
		if (rd_setup) begin
			unique case (paddr)
				cts_pkg::OFS_CTRL:  d.prdata = {22'h00_0000, q.ctrl};
				cts_pkg::OFS_TADDR: d.prdata = {15'h0000, q.taddr};
				cts_pkg::OFS_VPOS:  d.prdata = {15'h0000, q.vpos};
				cts_pkg::OFS_HPOS:  d.prdata = {17'h0_0000, q.hpos};
				cts_pkg::OFS_TOUT:  d.prdata = {16'h0000, hdat, vdat};
				default:            d.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q      <= '0;
			q.ctrl <= cts_pkg::CTRL_RST;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign vertical_window_begin       = q.vbeg;
	assign horizontal_window_begin     = q.hbeg;
	assign table_interrupt             = q.irq;
	assign combined_waveform           = q.cw;
	assign general_vertical_function   = vdat[cts_pkg::TB_GP +: 4];
	assign general_horizontal_function = hdat[cts_pkg::TB_GP +: 4];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_vclear_wins: assert property (
		vtick && vclr |=> q.vpos == '0
	) else $error("frame counter not cleared");

	a_vload_value: assert property (
		vtick && !vclr && fload |=> q.vpos == 17'h0_8000
	) else $error("frame counter not loaded with 8000h");

	a_load_over_bit: assert property (
		vtick && fclr_sel == 2'h0 && fload |=> q.vpos == 17'h0_8000
	) else $error("table clear bit beat frame load");

	a_vhold_noinc: assert property (
		vtick && !vclr && !fload && !vinc |=> $stable(q.vpos)
	) else $error("frame counter moved while inhibited");

	a_vline_clock: assert property (
		!vtick |=> $stable(q.vpos)
	) else $error("frame counter moved without line clock");

	a_vstick_hold: assert property (
		vtick && vstick && !vclr && !fload |=> q.vpos == 17'h0_7FF0
	) else $error("frame counter left stick point");

	a_hclear_wins: assert property (
		q.htick && hclr |=> q.hpos == '0
	) else $error("line counter not cleared");

	a_hload_value: assert property (
		q.htick && !hclr && hload |=> q.hpos == 15'h2000
	) else $error("line counter not loaded with 2000h");

	a_hinc_step: assert property (
		q.htick && !hclr && !hload && hinc |=> q.hpos == $past(q.hpos) + 15'h0001
	) else $error("line counter did not step by one");

	a_hdiv_spacing: assert property (
		q.htick |=> !q.htick [*8]
	) else $error("line counter clocked too often");

	// Tables are undefined until software fills them, so only while scanning
	a_cw_and: assert property (
		q.ctrl[cts_pkg::C_RUN] |=> q.cw == ($past(vdat[7:4]) & $past(hdat[7:4]))
	) else $error("combined waveform mismatch");

	a_vinc_step: assert property (
		vtick && !vclr && !fload && vinc |=> q.vpos == $past(q.vpos) + 17'h0_0001
	) else $error("frame counter did not step by one");

	a_vzero_hold: assert property (
		vtick && !vclr && !fload && vzhold |=> q.vpos == '0
	) else $error("frame counter left zero without trigger");

	a_hhold_noinc: assert property (
		q.htick && !hclr && !hload && !hinc |=> $stable(q.hpos)
	) else $error("line counter moved while inhibited");

	a_hzero_hold: assert property (
		q.htick && !hclr && !hload && hzhold |=> q.hpos == '0
	) else $error("line counter left zero without encoder");

	a_irq_entry: assert property (
		q.vn[1] && vdat[cts_pkg::TB_IRQ] |=> table_interrupt
	) else $error("entry interrupt bit gave no interrupt");

	a_vbeg_table: assert property (
		q.ctrl[cts_pkg::C_VWTAB] && q.vn[1] && vdat[cts_pkg::TB_BEGIN] |=> vertical_window_begin
	) else $error("vertical window begin missing");

	a_hbeg_entry: assert property (
		q.hn[1] && hdat[cts_pkg::TB_BEGIN] |=> horizontal_window_begin
	) else $error("horizontal window begin missing");

	c_vload: cover property (vtick && fload && !vclr);
	c_hload: cover property (q.htick && hload && !hclr);
	c_vstick: cover property (vtick && vstick);
	c_vzero_release: cover property (vtick && q.vpos == '0 && q.tpend);
	c_hzero_release: cover property (q.htick && q.hpos == '0 && q.epend);

endmodule

/* File: bench/cts_camera_model.sv */
/*
 * Camera and industrial signal model: free running pixel clock,
 * frame valid, line valid, trigger and encoder pulses on request.
 * Assumes the bench calls pulse() and nothing else drives the pins.
 */
`timescale 1ns/1ps
module cts_camera_model #(
	parameter real PPIX = 110.0
) (
	output logic pixel_clock_in,
	output logic frame_valid_input,
	output logic line_valid_input,
	output logic trigger_in,
	output logic encoder_in
);
	// ----------------------------------------
	// Pins
	// ----------------------------------------
	logic [3:0] pins_q = 4'h0;

	initial pixel_clock_in = 1'b0;
	// Runs free, phase unrelated to clk_sys
	always #(PPIX / 2.0) pixel_clock_in = ~pixel_clock_in;
	assign frame_valid_input = pins_q[0];
	assign line_valid_input  = pins_q[2];
	assign trigger_in        = pins_q[3];
	assign encoder_in        = pins_q[1];

	// Bit 0 frame, 1 encoder, 2 line, 3 trigger; held eight pixel clocks so the
	// synchroniser cannot miss either edge
	task automatic pulse(input logic [3:0] which);
		@(posedge pixel_clock_in);
		pins_q = pins_q | which;
		repeat (8) @(posedge pixel_clock_in);
		pins_q = pins_q & ~which;
		repeat (8) @(posedge pixel_clock_in);
	endtask
endmodule

/* File: bench/tb_top.sv */
/*
 * Self-checking bench of the control table sequencer: APB master,
 * table model and counter expectations.
 * Assumes cts_pkg and the camera model are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
	localparam real PPIX = 110.0;
	logic        clk_sys = 1'b0;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rv;
	logic        ev;
	logic        pready;
	logic        pslverr;
	logic        pixel_clock_in;
	logic        frame_valid_input;
	logic        line_valid_input;
	logic        trigger_in;
	logic        encoder_in;
	logic        vertical_window_begin;
	logic        horizontal_window_begin;
	logic        table_interrupt;
	logic [3:0]  general_vertical_function;
	logic [3:0]  general_horizontal_function;
	logic [3:0]  combined_waveform;
	logic [7:0]  vt [int];
	logic [7:0]  ht [int];
	int          err_total    = 0;
	int          total_checks = 0;
	int          n_v          = 0;
	int          n_h          = 0;
	int          n_i          = 0;
	int          lo;
	int          hi;
	realtime     t0;

	always #12.5 clk_sys = ~clk_sys;

	cts_sequencer dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pixel_clock_in, .frame_valid_input,
		.line_valid_input, .trigger_in, .encoder_in, .vertical_window_begin,
		.horizontal_window_begin, .table_interrupt, .general_vertical_function,
		.general_horizontal_function, .combined_waveform);

	cts_camera_model #(.PPIX(PPIX)) cam (.pixel_clock_in, .frame_valid_input,
		.line_valid_input, .trigger_in, .encoder_in);

	// X pulses are not counted, so unwritten entries cannot inflate them
	always @(posedge clk_sys) begin
		if (vertical_window_begin === 1'b1) n_v++;
		if (horizontal_window_begin === 1'b1) n_h++;
		if (table_interrupt === 1'b1) n_i++;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic complete_run();
		if (err_total == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 64);
		if (n >= 64) err_total++;
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wt(input int a, input logic [7:0] d, input logic v);
		apb(1'b1, cts_pkg::OFS_TADDR, 32'(a));
		apb(1'b1, v ? cts_pkg::OFS_VWR : cts_pkg::OFS_HWR, {24'h0, d});
		if (v) vt[a] = d;
		else ht[a] = d;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		rst_n <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		void'($urandom(32'h0fb9));
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		apb(1'b0, cts_pkg::OFS_CTRL, 32'h0);
		chk(rv, {22'h0, cts_pkg::CTRL_RST});
		apb(1'b0, 8'h1C, 32'h0);
		chk({ev, rv[30:0]}, 32'h8000_0000);
		apb(1'b1, cts_pkg::OFS_VPOS, 32'h5);
		apb(1'b0, cts_pkg::OFS_VPOS, 32'h0);
		chk(rv, 32'h0);
		// Tables first, scanning enabled only afterwards
		wt(0, {4'($urandom()), 4'h4}, 1'b0);
		wt(1, {4'($urandom()), 4'h2}, 1'b0);
		wt('h2000, {4'($urandom()), 4'h3}, 1'b0);
		wt(0, {4'($urandom()), 4'h6}, 1'b1);
		wt('h8000, {4'($urandom()), 4'hD}, 1'b1);
		// Entries the frame counter walks through while counting lines
		for (int k = 1; k < 32; k++) begin
			wt(k, 8'($urandom()), 1'b1);
		end
		apb(1'b1, cts_pkg::OFS_CTRL, 32'h206);
		repeat (300) @(posedge clk_sys);
		apb(1'b0, cts_pkg::OFS_TOUT, 32'h0);
		chk(rv, {16'h0, ht[0], vt[0]});
		chk(32'(general_vertical_function), 32'(vt[0][7:4]));
		chk(32'(general_horizontal_function), 32'(ht[0][7:4]));
		chk(32'(combined_waveform), 32'(vt[0][7:4] & ht[0][7:4]));
		apb(1'b0, cts_pkg::OFS_HPOS, 32'h0);
		chk(rv, 32'h0);
		// Line load to 2000h shows as one window pulse, then table clear
		cam.pulse(4'h4);
		repeat (300) @(posedge clk_sys);
		chk(32'(n_h), 32'h1);
		apb(1'b0, cts_pkg::OFS_HPOS, 32'h0);
		chk(rv, 32'h0);
		// Frame load against the table clear bit: the load wins
		cam.pulse(4'h1);
		cam.pulse(4'h4);
		repeat (300) @(posedge clk_sys);
		apb(1'b0, cts_pkg::OFS_VPOS, 32'h0);
		chk(rv, 32'h8000);
		chk(32'(n_v), 32'h1);
		chk(32'(n_i), 32'h1);
		// Trigger clear against a masked-in frame load: the clear wins
		apb(1'b1, cts_pkg::OFS_CTRL, 32'h216);
		cam.pulse(4'h9);
		cam.pulse(4'h4);
		repeat (300) @(posedge clk_sys);
		apb(1'b0, cts_pkg::OFS_VPOS, 32'h0);
		chk(rv, 32'h0);
		// Hold at zero until trigger, then one count per line
		apb(1'b1, cts_pkg::OFS_CTRL, 32'h23F);
		repeat (400) @(posedge clk_sys);
		apb(1'b0, cts_pkg::OFS_VPOS, 32'h0);
		chk(rv, 32'h0);
		cam.pulse(4'h8);
		t0 = $realtime;
		repeat (1200) @(posedge clk_sys);
		apb(1'b1, cts_pkg::OFS_CTRL, 32'h23E);
		lo = int'(($realtime - t0) / (16.0 * PPIX)) - 3;
		hi = lo + 6;
		repeat (200) @(posedge clk_sys);
		apb(1'b0, cts_pkg::OFS_VPOS, 32'h0);
		chk(32'(int'(rv) >= lo && int'(rv) <= hi), 32'h1);
		lo = int'(rv);
		repeat (300) @(posedge clk_sys);
		apb(1'b0, cts_pkg::OFS_VPOS, 32'h0);
		chk(rv, 32'(lo));
		apb(1'b0, cts_pkg::OFS_HPOS, 32'h0);
		chk(32'(rv <= 32'h1), 32'h1);
		// Line held at zero until the encoder releases exactly one line
		apb(1'b1, cts_pkg::OFS_CTRL, 32'h2B7);
		repeat (300) @(posedge clk_sys);
		apb(1'b0, cts_pkg::OFS_HPOS, 32'h0);
		chk(rv, 32'h0);
		apb(1'b0, cts_pkg::OFS_VPOS, 32'h0);
		chk(rv, 32'(lo));
		cam.pulse(4'h2);
		repeat (300) @(posedge clk_sys);
		apb(1'b0, cts_pkg::OFS_VPOS, 32'h0);
		chk(rv, 32'(lo + 1));
		apb(1'b0, cts_pkg::OFS_HPOS, 32'h0);
		chk(rv, 32'h0);
		complete_run();
	end

	initial begin
		#(25.0 * 20000);
		err_total++;
		complete_run();
	end
endmodule
